// file: include/dlsi_pkg.sv
// Summary of operation
// - test running: LED alternates red/green at 5 Hz
// - selector zero: required comm error gives red
// - required drive error, comm intact: red+green
// - extras present, no extra error: green 2 Hz
// - extra drive error: red+green flash 2 Hz
// - exactly required drives healthy: steady green
// - selector nonzero: show only selected drive
// - presence test starts by itself after power-up
// - found drive gets stored baud and timeout
// - every found drive gets serial address one
// - restore stored required marks at start-up
// - test end: missing red, exact green, more flash
// - factory default: no port marked required
// - run commands refused unless drive required
// - retest code written reruns presence test
// - nonzero alias switches set alias, else stored
// - port LED off, on, or 10 Hz flicker
// - single-drive variant reports its one drive
package dlsi_pkg;
  // clock and blink timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BLINK_5HZ = 5;
  localparam int BLINK_2HZ = 2;
  localparam int BLINK_10HZ = 10;
  localparam int HALF_5HZ_CYC = CLK_HZ / (2 * BLINK_5HZ);
  localparam int HALF_2HZ_CYC = CLK_HZ / (2 * BLINK_2HZ);
  localparam int HALF_10HZ_CYC = CLK_HZ / (2 * BLINK_10HZ);
  // index of each rate in the blink bank
  localparam int BLK_5 = 0;
  localparam int BLK_2 = 1;
  localparam int BLK_10 = 2;
  // presence test settle window
  localparam int TEST_TIME_MS = 10;
  localparam int TEST_CYC = (CLK_HZ / 1000) * TEST_TIME_MS;
  // drive ports on a hub
  localparam int NUM_DRIVES_DEF = 8;
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ALIAS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_REQ_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] REG_BAUD_BASE = 8'h40;
  localparam int STATUS_BUSY_BIT = 16;
  localparam logic [31:0] RETEST_CODE = 32'hfffffffd;
  // per-drive configuration values
  localparam int BAUD_W = 3;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 3'h0;
  localparam logic [7:0] CFG_ADDR = 8'h01;
  localparam logic [15:0] MSG_TIMEOUT_BASE = 16'h0800;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic red;
    logic green;
  } dlsi_led_type;

  typedef struct packed {
    logic [2:0] port;
    logic [BAUD_W-1:0] baud;
    logic [15:0] timeout;
    logic [7:0] addr;
  } dlsi_cfg_type;

  typedef enum {PT_LOAD, PT_WAIT, PT_CFG, PT_IDLE} dlsi_pt_state_type;

  // message-complete time halves with each faster baud step
  function automatic logic [15:0] dlsi_timeout_for(input logic [BAUD_W-1:0] baud);
    return MSG_TIMEOUT_BASE >> baud;
  endfunction
endpackage

// file: src/dlsi_top.sv
`timescale 1ns/10ps
`default_nettype none
module dlsi_top
  import dlsi_pkg::*;
#(
  parameter int NUM_DRIVES = NUM_DRIVES_DEF,
  parameter int HALF_5HZ = HALF_5HZ_CYC,
  parameter int HALF_2HZ = HALF_2HZ_CYC,
  parameter int HALF_10HZ = HALF_10HZ_CYC,
  parameter int TEST_CYCLES = TEST_CYC
)(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [NUM_DRIVES-1:0] I_DRIVE_PRESENT,
  input wire logic [NUM_DRIVES-1:0] I_COMM_ERR,
  input wire logic [NUM_DRIVES-1:0] I_DRIVE_ERR,
  input wire logic [NUM_DRIVES-1:0] I_RUN_REQ,
  output logic [NUM_DRIVES-1:0] O_RUN_EN,
  input wire logic I_NV_VALID,
  input wire logic [NUM_DRIVES-1:0] I_NV_REQUIRED,
  input wire logic [3:0] I_DRIVE_SELECT_SW,
  input wire logic [7:0] I_ALIAS_ROTARY_SW,
  output logic [7:0] O_STATION_ALIAS,
  input wire logic [1:0] I_LINK_UP,
  input wire logic [1:0] I_LINK_ACT,
  output logic [1:0] O_NETWORK_PORT_LED,
  output var dlsi_led_type O_DRIVE_LINK_STATUS_LED,
  output logic O_CFG_VALID,
  output var dlsi_cfg_type O_CFG,
  output logic O_TEST_BUSY
);
  localparam int SYNC_W = NUM_DRIVES + 16;
  localparam int HALF_ARR [3] = '{HALF_5HZ, HALF_2HZ, HALF_10HZ};

  // pin synchroniser, first stage read only by the second
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  wire [SYNC_W-1:0] async_in = {I_DRIVE_PRESENT, I_DRIVE_SELECT_SW, I_ALIAS_ROTARY_SW, I_LINK_UP, I_LINK_ACT};
  wire [NUM_DRIVES-1:0] present_sync = sync2_reg[SYNC_W-1:16];
  wire [3:0] sel_sync = sync2_reg[15:12];
  wire [7:0] alias_sync = sync2_reg[11:4];
  wire [1:0] link_sync = sync2_reg[3:2];
  wire [1:0] act_sync = sync2_reg[1:0];

  // two flops on the presence, selector, alias and link pin inputs
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // blink bank: one half-duty divider per rate
  logic [2:0] blink;
  logic [2:0] blink_wrap;
  for (genvar b = 0; b < 3; b++) begin : g_blink
    logic [23:0] cnt_reg; // cycles in current half period
    logic tog_reg; // blink phase
    assign blink_wrap[b] = (cnt_reg == 24'(HALF_ARR[b] - 1));
    assign blink[b] = tog_reg;
    // toggle each half period gives 50 percent duty
    always_ff @(posedge I_CLK) begin
      if (I_RST) begin
        cnt_reg <= '0;
        tog_reg <= 1'b0;
      end else if (blink_wrap[b]) begin
        cnt_reg <= '0;
        tog_reg <= ~tog_reg;
      end else begin
        cnt_reg <= cnt_reg + 24'h000001;
      end
    end
  end

  // bus write side state
  logic aw_have_reg; // address held
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_have_reg; // data held
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  // bus read side state
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // presence test state
  dlsi_pt_state_type state_reg, state_next;
  logic [23:0] wait_cnt_reg;
  logic [2:0] port_reg; // port being configured
  logic [NUM_DRIVES-1:0] present_reg; // result of the last test
  logic [NUM_DRIVES-1:0] required_reg; // ports released for run commands
  logic [7:0] alias_store_reg; // last stored station alias
  logic [7:0] alias_reg;
  logic cfg_valid_reg;
  dlsi_cfg_type cfg_reg;
  dlsi_led_type led_reg, led_next;
  logic [1:0] port_led_reg;
  logic [1:0] act_seen_reg; // activity within the current flicker phase
  logic [BAUD_W-1:0] baud_reg [NUM_DRIVES]; // stored baud code per drive

  // write handshake: address and data accepted in either order
  assign O_AWREADY = !aw_have_reg && !bvalid_reg;
  assign O_WREADY = !w_have_reg && !bvalid_reg;
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;
  assign O_ARREADY = !rvalid_reg;
  assign O_RVALID = rvalid_reg;
  assign O_RDATA = rdata_reg;
  assign O_RRESP = rresp_reg;
  wire aw_fire = I_AWVALID && O_AWREADY;
  wire w_fire = I_WVALID && O_WREADY;
  wire ar_fire = I_ARVALID && O_ARREADY;
  wire wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  // write decode on the held address
  wire wr_ctrl = (aw_addr_reg == REG_CTRL);
  wire wr_status = (aw_addr_reg == REG_STATUS);
  wire wr_alias = (aw_addr_reg == REG_ALIAS);
  wire retest_hit = wr_fire && wr_ctrl && (w_data_reg == RETEST_CODE) && (w_strb_reg == 4'hf);
  // read decode on the offered address
  wire rd_ctrl = (I_ARADDR == REG_CTRL);
  wire rd_status = (I_ARADDR == REG_STATUS);
  wire rd_alias = (I_ARADDR == REG_ALIAS);
  wire test_busy = (state_reg != PT_IDLE);

  // per-drive decode, storage and run gating
  logic [NUM_DRIVES-1:0] wr_req_hit;
  logic [NUM_DRIVES-1:0] wr_baud_hit;
  logic [NUM_DRIVES-1:0] rd_req_hit;
  logic [NUM_DRIVES-1:0] rd_baud_hit;
  logic [NUM_DRIVES-1:0] rd_req_bit;
  logic [BAUD_W-1:0] rd_baud_val [NUM_DRIVES];
  for (genvar n = 0; n < NUM_DRIVES; n++) begin : g_drive
    localparam logic [ADDR_W-1:0] REQ_OFF = REG_REQ_BASE + ADDR_W'(4 * n);
    localparam logic [ADDR_W-1:0] BAUD_OFF = REG_BAUD_BASE + ADDR_W'(4 * n);
    assign wr_req_hit[n] = (aw_addr_reg == REQ_OFF);
    assign wr_baud_hit[n] = (aw_addr_reg == BAUD_OFF);
    assign rd_req_hit[n] = (I_ARADDR == REQ_OFF);
    assign rd_baud_hit[n] = (I_ARADDR == BAUD_OFF);
    assign rd_req_bit[n] = rd_req_hit[n] && required_reg[n];
    assign rd_baud_val[n] = rd_baud_hit[n] ? baud_reg[n] : '0;
    // only drives marked required, by the start-up restore or by software, may run
    assign O_RUN_EN[n] = I_RUN_REQ[n] && required_reg[n];

    // required mark: cleared at reset, restored once, then software owned
    always_ff @(posedge I_CLK) begin
      if (I_RST) begin
        required_reg[n] <= 1'b0;
      end else if (state_reg == PT_LOAD) begin
        required_reg[n] <= I_NV_VALID && I_NV_REQUIRED[n];
      end else if (wr_fire && wr_req_hit[n] && w_strb_reg[0]) begin
        required_reg[n] <= w_data_reg[0];
      end
    end

    // stored baud code used when the test configures the drive
    always_ff @(posedge I_CLK) begin
      if (I_RST) begin
        baud_reg[n] <= BAUD_RESET;
      end else if (wr_fire && wr_baud_hit[n] && w_strb_reg[0]) begin
        baud_reg[n] <= w_data_reg[BAUD_W-1:0];
      end
    end
  end

  // read data mux, unmapped reads give zero
  logic [31:0] rd_mux;
  logic rd_mapped;
  always_comb begin
    rd_mux = '0;
    rd_mapped = rd_ctrl || rd_status || rd_alias || (|rd_req_hit) || (|rd_baud_hit);
    if (rd_ctrl) begin
      rd_mux[0] = test_busy;
    end
    if (rd_status) begin
      rd_mux[NUM_DRIVES-1:0] = present_reg;
      rd_mux[STATUS_BUSY_BIT] = test_busy;
    end
    if (rd_alias) begin
      rd_mux[15:0] = {alias_reg, alias_store_reg};
    end
    rd_mux[0] = rd_mux[0] | (|rd_req_bit);
    for (int k = 0; k < NUM_DRIVES; k++) begin
      rd_mux[BAUD_W-1:0] = rd_mux[BAUD_W-1:0] | rd_baud_val[k];
    end
  end
  wire wr_mapped = wr_ctrl || wr_status || wr_alias || (|wr_req_hit) || (|wr_baud_hit);

  // write channel bookkeeping and response
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= I_AWADDR;
      end
      if (w_fire) begin
        w_have_reg <= 1'b1;
        w_data_reg <= I_WDATA;
        w_strb_reg <= I_WSTRB;
      end
      if (wr_fire) begin // both halves held: commit and answer
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && I_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && I_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // stored alias written by software, low byte lane only
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      alias_store_reg <= '0;
      alias_reg <= '0;
    end else begin
      if (wr_fire && wr_alias && w_strb_reg[0]) begin
        alias_store_reg <= w_data_reg[7:0];
      end
      alias_reg <= (alias_sync != 8'h00) ? alias_sync : alias_store_reg;
    end
  end
  assign O_STATION_ALIAS = alias_reg;

  // presence test sequencing
  wire wait_done = (wait_cnt_reg == 24'(TEST_CYCLES - 1));
  wire last_port = (port_reg == 3'(NUM_DRIVES - 1));
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PT_LOAD: state_next = PT_WAIT; // automatic start after reset
      PT_WAIT: state_next = wait_done ? PT_CFG : PT_WAIT;
      PT_CFG: state_next = last_port ? PT_IDLE : PT_CFG;
      PT_IDLE: state_next = PT_IDLE;
      default: state_next = PT_IDLE;
    endcase
    // a retest restarts the window even mid test
    if (retest_hit) begin
      state_next = PT_WAIT;
    end
  end

  // test counters, presence capture and config pulses
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg <= PT_LOAD;
      wait_cnt_reg <= '0;
      port_reg <= '0;
      present_reg <= '0;
      cfg_valid_reg <= 1'b0;
      cfg_reg <= '0;
    end else begin
      state_reg <= state_next;
      cfg_valid_reg <= 1'b0;
      if (retest_hit || (state_next == PT_WAIT && state_reg != PT_WAIT)) begin
        wait_cnt_reg <= '0;
      end else if (state_reg == PT_WAIT) begin
        wait_cnt_reg <= wait_cnt_reg + 24'h000001;
      end
      if (state_reg == PT_WAIT && wait_done && !retest_hit) begin
        present_reg <= present_sync;
        port_reg <= '0;
      end
      if (state_reg == PT_CFG) begin
        port_reg <= port_reg + 3'h1;
        if (present_reg[port_reg]) begin
          cfg_valid_reg <= 1'b1;
          cfg_reg.port <= port_reg;
          cfg_reg.baud <= baud_reg[port_reg];
          cfg_reg.timeout <= dlsi_timeout_for(baud_reg[port_reg]);
          cfg_reg.addr <= CFG_ADDR;
        end
      end
    end
  end
  assign O_CFG_VALID = cfg_valid_reg;
  assign O_CFG = cfg_reg;
  assign O_TEST_BUSY = test_busy;

  // collective health terms; a missing required drive counts as comm error
  wire [NUM_DRIVES-1:0] req_comm = required_reg & (~present_reg | I_COMM_ERR);
  wire [NUM_DRIVES-1:0] req_derr = required_reg & present_reg & ~I_COMM_ERR & I_DRIVE_ERR;
  wire [NUM_DRIVES-1:0] extra = present_reg & ~required_reg;
  wire any_req_comm = |req_comm;
  wire any_req_derr = |req_derr;
  wire any_extra = |extra;
  wire any_extra_derr = |(extra & I_DRIVE_ERR);
  // selected drive, out-of-range positions show dark
  wire [3:0] sel_idx = sel_sync - 4'h1;
  wire sel_valid = (sel_sync != 4'h0) && (sel_sync <= 4'(NUM_DRIVES));
  wire sel_pres = sel_valid && present_reg[sel_idx[2:0]];
  wire sel_req = sel_valid && required_reg[sel_idx[2:0]];
  wire sel_comm = sel_valid && I_COMM_ERR[sel_idx[2:0]];
  wire sel_derr = sel_valid && I_DRIVE_ERR[sel_idx[2:0]];

  // status LED priority; one drive on the adapter uses the same terms
  always_comb begin
    led_next = '0;
    if (test_busy) begin
      led_next.red = blink[BLK_5];
      led_next.green = ~blink[BLK_5];
    end else if (sel_sync != 4'h0) begin
      if (!sel_pres && !sel_req) begin
        led_next = '0;
      end else if (!sel_pres || sel_comm) begin
        led_next.red = 1'b1;
      end else if (sel_derr) begin
        led_next = '{red: 1'b1, green: 1'b1};
      end else begin
        led_next.green = 1'b1;
      end
    end else if (any_req_comm) begin
      led_next.red = 1'b1;
    end else if (any_req_derr) begin
      led_next = '{red: 1'b1, green: 1'b1};
    end else if (any_extra && any_extra_derr) begin
      led_next.red = blink[BLK_2];
      led_next.green = blink[BLK_2];
    end else if (any_extra) begin
      led_next.green = blink[BLK_2];
    end else begin
      led_next.green = 1'b1;
    end
  end

  // port LEDs; activity held for a flicker phase since pulses are short
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      led_reg <= '0;
      act_seen_reg <= '0;
      port_led_reg <= '0;
    end else begin
      led_reg <= led_next;
      // set wins over the phase clear so no burst is dropped
      act_seen_reg <= act_sync | (blink_wrap[BLK_10] ? 2'b00 : act_seen_reg);
      for (int p = 0; p < 2; p++) begin
        port_led_reg[p] <= link_sync[p] && (act_seen_reg[p] ? blink[BLK_10] : 1'b1);
      end
    end
  end
  assign O_DRIVE_LINK_STATUS_LED = led_reg;
  assign O_NETWORK_PORT_LED = port_led_reg;

  // checks on the design's own behaviour
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire idle0 = !test_busy && (sel_sync == 4'h0);

  property p_test_blink;
    test_busy |=> (O_DRIVE_LINK_STATUS_LED.red == $past(blink[BLK_5])) && (O_DRIVE_LINK_STATUS_LED.red != O_DRIVE_LINK_STATUS_LED.green);
  endproperty
  a_test_blink: assert property (p_test_blink) else $error("test pattern wrong");

  property p_req_comm_red;
    idle0 && any_req_comm |=> O_DRIVE_LINK_STATUS_LED.red && !O_DRIVE_LINK_STATUS_LED.green;
  endproperty
  a_req_comm_red: assert property (p_req_comm_red) else $error("required comm error not red");

  property p_req_derr_both;
    idle0 && !any_req_comm && any_req_derr |=> O_DRIVE_LINK_STATUS_LED.red && O_DRIVE_LINK_STATUS_LED.green;
  endproperty
  a_req_derr_both: assert property (p_req_derr_both) else $error("drive error not red green");

  property p_extra_flash;
    idle0 && !any_req_comm && !any_req_derr && any_extra && !any_extra_derr
      |=> !O_DRIVE_LINK_STATUS_LED.red && (O_DRIVE_LINK_STATUS_LED.green == $past(blink[BLK_2]));
  endproperty
  a_extra_flash: assert property (p_extra_flash) else $error("extra drive flash wrong");

  property p_exact_green;
    idle0 && !any_req_comm && !any_req_derr && !any_extra
      |=> O_DRIVE_LINK_STATUS_LED == dlsi_led_type'{red: 1'b0, green: 1'b1};
  endproperty
  a_exact_green: assert property (p_exact_green) else $error("exact set not green");

  property p_sel_dark;
    !test_busy && (sel_sync != 4'h0) && !sel_pres && !sel_req |=> O_DRIVE_LINK_STATUS_LED == '0;
  endproperty
  a_sel_dark: assert property (p_sel_dark) else $error("absent drive not dark");

  property p_cfg_fields;
    O_CFG_VALID |-> (O_CFG.addr == CFG_ADDR) && (O_CFG.timeout == (MSG_TIMEOUT_BASE >> O_CFG.baud))
      && present_reg[O_CFG.port];
  endproperty
  a_cfg_fields: assert property (p_cfg_fields) else $error("drive config wrong");

  property p_run_gate;
    O_RUN_EN != '0 |-> ((O_RUN_EN & ~required_reg) == '0);
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("run enabled for unrequired drive");

  property p_retest;
    retest_hit |=> (state_reg == PT_WAIT) && (wait_cnt_reg == 24'h0) ##1 O_TEST_BUSY [*3];
  endproperty
  a_retest: assert property (p_retest) else $error("retest did not restart");

  property p_alias;
    (alias_sync != 8'h00) && $stable(alias_sync) |=> O_STATION_ALIAS == $past(alias_sync);
  endproperty
  a_alias: assert property (p_alias) else $error("switch alias not used");

  property p_link_off;
    !link_sync[0] |=> !O_NETWORK_PORT_LED[0];
  endproperty
  a_link_off: assert property (p_link_off) else $error("port led lit without link");
endmodule
`default_nettype wire

// file: verif/dlsi_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the drives on the serial links
module dlsi_drive_model
  import dlsi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_attach, // drives plugged in
  input wire logic [7:0] i_comm_fault, // links broken
  input wire logic [7:0] i_drive_fault, // drives in fault
  input wire logic i_cfg_valid,
  input var dlsi_cfg_type i_cfg,
  output logic [7:0] o_present,
  output logic [7:0] o_comm_err,
  output logic [7:0] o_drive_err,
  output int o_n_cfg, // configuration pulses seen
  output logic [7:0] o_addr_last, // last serial address given
  output logic [15:0] o_tmo [8] // timeout given to each port
);
  // absent drives report nothing; a dead link hides drive faults
  always_ff @(posedge i_clk) begin
    o_present <= i_attach;
    o_comm_err <= i_comm_fault & i_attach;
    o_drive_err <= i_drive_fault & i_attach & ~i_comm_fault;
  end
  // each pulse sets one drive's timeout and address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_n_cfg <= 0;
      o_addr_last <= 8'h00;
    end else if (i_cfg_valid) begin
      o_n_cfg <= o_n_cfg + 1;
      o_addr_last <= i_cfg.addr;
      o_tmo[i_cfg.port] <= i_cfg.timeout;
    end
  end
endmodule
`default_nettype wire

// file: verif/drive_link_status_indicator_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// bench: register tasks, drive model, led pattern counting
module drive_link_status_indicator_tb_top
  import dlsi_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, nv_valid = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, alias_sw = 8'h00, run_req = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic [7:0] attach = 8'h03, cfault = 8'h00, dfault = 8'h00, nv_req = 8'h03;
  logic [3:0] sel_sw = 4'h0, strb = 4'hf;
  logic [1:0] link_up = 2'h0, link_act = 2'h0, r, bresp, rresp, port_led;
  logic awready, wready, bvalid, arready, rvalid, cfg_valid, busy;
  logic [31:0] rdata;
  logic [7:0] present, comm_err, drive_err, run_en, st_alias, cfg_addr;
  logic [15:0] tmo [8];
  dlsi_led_type led;
  dlsi_cfg_type cfg;
  int n_cfg, t [4];
  int n_fail = 0, cmp_count = 0;
  // selector positions and the led each should give
  logic [3:0] sels [4] = '{4'h2, 4'h4, 4'h1, 4'h1};
  logic [1:0] exps [4] = '{2'b11, 2'b00, 2'b01, 2'b10};

  always #20 clk = ~clk;

  // short blink counts keep the run small
  dlsi_top #(.NUM_DRIVES(8), .HALF_5HZ(8), .HALF_2HZ(20), .HALF_10HZ(4), .TEST_CYCLES(16)) u_dlsi_top (
    .I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(strb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_DRIVE_PRESENT(present), .I_COMM_ERR(comm_err), .I_DRIVE_ERR(drive_err),
    .I_RUN_REQ(run_req), .O_RUN_EN(run_en), .I_NV_VALID(nv_valid), .I_NV_REQUIRED(nv_req),
    .I_DRIVE_SELECT_SW(sel_sw), .I_ALIAS_ROTARY_SW(alias_sw), .O_STATION_ALIAS(st_alias),
    .I_LINK_UP(link_up), .I_LINK_ACT(link_act), .O_NETWORK_PORT_LED(port_led),
    .O_DRIVE_LINK_STATUS_LED(led), .O_CFG_VALID(cfg_valid), .O_CFG(cfg), .O_TEST_BUSY(busy));

  dlsi_drive_model u_dlsi_drive_model (
    .i_clk(clk), .i_rst(rst), .i_attach(attach), .i_comm_fault(cfault), .i_drive_fault(dfault),
    .i_cfg_valid(cfg_valid), .i_cfg(cfg), .o_present(present), .o_comm_err(comm_err),
    .o_drive_err(drive_err), .o_n_cfg(n_cfg), .o_addr_last(cfg_addr), .o_tmo(tmo));

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // outputs are read mid-cycle, where they are settled
  task automatic look;
    @(negedge clk);
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_go, w_go;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      look;
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end while ((awvalid && !aw_go) || (wvalid && !w_go));
    bready <= 1'b1;
    do begin
      look;
      r = bresp;
      aw_go = bvalid;
      @(posedge clk);
    end while (!aw_go);
    bready <= 1'b0;
    check_val({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic go;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      look;
      go = arready;
      @(posedge clk);
    end while (!go);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      look;
      d = rdata;
      r = rresp;
      go = rvalid;
      @(posedge clk);
    end while (!go);
    rready <= 1'b0;
  endtask
  // toggles of red, green, port1, port0 over n cycles
  task automatic count_tg(input int n);
    logic [3:0] p, v;
    t = '{0, 0, 0, 0};
    look;
    p = {led, port_led};
    repeat (n) begin
      look;
      v = {led, port_led};
      for (int i = 0; i < 4; i++) if (v[i] !== p[i]) t[3-i]++;
      p = v;
    end
  endtask
  // bounded wait, the test is only a few dozen cycles
  task automatic wait_idle;
    int k;
    k = 0;
    look;
    while (busy !== 1'b0 && k < 200) begin
      look;
      k++;
    end
    check_val({31'h0, busy}, 32'h0, "test end");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog, far beyond the five hundred or so cycles the tests need
  initial begin
    cyc(20000);
    n_fail++;
    complete_run;
  end

  // main sequence
  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(5);
    look;
    check_val({31'h0, busy}, 32'h1, "busy after reset");
    check_val({31'h0, led.red ^ led.green}, 32'h1, "test alternation");
    count_tg(12);
    check_val(32'(t[0] >= 1 && t[0] == t[1]), 32'h1, "5 Hz alternation");
    wait_idle;
    cyc(4);
    look;
    check_val(32'(n_cfg), 32'h2, "config pulses");
    check_val({24'h0, cfg_addr}, {24'h0, CFG_ADDR}, "serial address");
    check_val({16'h0, tmo[1]}, {16'h0, MSG_TIMEOUT_BASE}, "timeout baud 0");
    check_val({30'h0, led}, 32'h1, "exact drives green");
    axi_rd(REG_STATUS);
    check_val(d, 32'h3, "present mask");
    axi_rd(REG_REQ_BASE + 8'h04);
    check_val(d, 32'h1, "required restored");
    run_req <= 8'hff;
    look;
    check_val({24'h0, run_en}, 32'h3, "run gate");
    cyc(1);
    cfault <= 8'h01;
    cyc(6);
    look;
    check_val({30'h0, led}, 32'h2, "comm error red");
    cyc(1);
    cfault <= 8'h00;
    dfault <= 8'h02;
    cyc(6);
    count_tg(30);
    check_val({30'h0, led} | 32'(t[0] + t[1]), 32'h3, "drive error steady");
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      sel_sw <= sels[i];
      cfault <= (i == 3) ? 8'h01 : 8'h00;
      cyc(6);
      look;
      check_val({30'h0, led}, {30'h0, exps[i]}, "selected drive");
    end
    cyc(1);
    sel_sw <= 4'h0;
    cfault <= 8'h00;
    dfault <= 8'h00;
    // low lane only: the retest code is ignored, the baud byte still lands
    strb <= 4'h1;
    axi_wr(REG_CTRL, RETEST_CODE);
    axi_wr(REG_BAUD_BASE, 32'h2);
    strb <= 4'hf;
    attach <= 8'h07;
    look;
    check_val({31'h0, busy}, 32'h0, "partial retest ignored");
    axi_wr(REG_CTRL, RETEST_CODE);
    cyc(2);
    look;
    check_val({31'h0, busy}, 32'h1, "retest started");
    wait_idle;
    cyc(4);
    look;
    check_val(32'(n_cfg), 32'h5, "retest pulses");
    check_val({16'h0, tmo[0]}, {16'h0, MSG_TIMEOUT_BASE >> 2}, "timeout baud 2");
    count_tg(100);
    check_val(32'(t[1] >= 4 && t[1] <= 6 && t[0] == 0 && led.red === 1'b0), 32'h1, "extra green");
    cyc(1);
    dfault <= 8'h04;
    cyc(6);
    count_tg(100);
    check_val(32'(t[0] >= 4 && t[0] <= 6 && led.red === led.green), 32'h1, "extra error");
    cyc(1);
    dfault <= 8'h00;
    axi_wr(REG_REQ_BASE + 8'h08, 32'h1);
    look;
    check_val({24'h0, run_en}, 32'h7, "run gate drive 3");
    axi_wr(REG_ALIAS, 32'h5a);
    cyc(6);
    look;
    check_val({24'h0, st_alias}, 32'h5a, "stored alias");
    cyc(1);
    alias_sw <= 8'h12;
    link_up <= 2'b10;
    cyc(6);
    look;
    check_val({24'h0, st_alias}, 32'h12, "switch alias");
    check_val({30'h0, port_led}, 32'h2, "link without traffic");
    cyc(1);
    link_up <= 2'b11;
    link_act <= 2'b01;
    cyc(6);
    count_tg(40);
    check_val(32'(t[3] >= 8 && t[3] <= 12 && t[2] == 0), 32'h1, "traffic flicker");
    axi_rd(8'hfc);
    check_val({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
    rst <= 1'b1;
    nv_valid <= 1'b0;
    cyc(3);
    rst <= 1'b0;
    axi_rd(REG_REQ_BASE);
    check_val(d, 32'h0, "factory default");
    look;
    check_val({24'h0, run_en}, 32'h0, "default refuses run");
    complete_run;
  end
endmodule
`default_nettype wire
